// File: core/twb_host_pkg.sv
/*
  Package for the two-wire bus host controller: the map of the bus interface
  registers that the host drives, the bit layout of its control and status
  registers, the host's own APB register map and the engine state encoding.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package twb_host_pkg;

   // ----------------------------------------------------------------------
   // Register indices of the bus interface reached over the device port
   // ----------------------------------------------------------------------
   localparam logic [1:0] DEV_CTRL_IDX   = 2'h0; // bus_control_reg
   localparam logic [1:0] DEV_STAT_IDX   = 2'h1; // bus_status_reg
   localparam logic [1:0] DEV_DATA_IDX   = 2'h2; // bus_data_reg

   // Bits of bus_control_reg.
   localparam int BIT_IF_ENABLE  = 7;
   localparam int BIT_IRQ_ENABLE = 6; // irq_enable_bit
   localparam int BIT_MASTER_SEL = 5; // master_select_bit
   localparam int BIT_TX_SEL     = 4; // transmit_select_bit
   localparam int BIT_ACK_DIS    = 3; // ack_disable_bit

   // Bits of bus_status_reg.
   localparam int BIT_BYTE_DONE  = 7; // byte_done_flag
   localparam int BIT_ADDR_SLAVE = 6; // addressed_slave_flag
   localparam int BIT_BUS_BUSY   = 5; // bus_busy_flag
   localparam int BIT_ARB_LOST   = 4; // arb_lost_flag
   localparam int BIT_RW_LATCH   = 2; // latched_rw_bit
   localparam int BIT_PEND_IRQ   = 1; // pending_irq_flag
   localparam int BIT_RX_ACK     = 0; // rx_ack_status

   // ----------------------------------------------------------------------
   // Host registers on APB (byte offsets)
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_ADDR   = 8'h04;
   localparam logic [7:0] OFS_COUNT  = 8'h08;
   localparam logic [7:0] OFS_TXDATA = 8'h0c;
   localparam logic [7:0] OFS_RXDATA = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;

   // Bits of the host CTRL register.
   localparam int CTL_GO    = 0;
   localparam int CTL_READ  = 1;
   localparam int CTL_HOLD  = 2;
   localparam int CTL_SLAVE = 3;

   // Bits of the host STATUS register; the byte count left sits in 15:8.
   localparam int STS_BUSY   = 0;
   localparam int STS_DONE   = 1;
   localparam int STS_NACK   = 2;
   localparam int STS_ARB    = 3;
   localparam int STS_TXFULL = 4;
   localparam int STS_RXFULL = 5;
   localparam int STS_OWNED  = 6;
   localparam int STS_SLTX   = 7;

   // Reset values.
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // ----------------------------------------------------------------------
   // Engine states, Gray coded in declaration order; every access passes through S_ACC
   // ----------------------------------------------------------------------
   typedef enum logic [4:0] {
      S_INIT     = 5'h00,
      S_IDLE     = 5'h01,
      S_BUS_CHK  = 5'h03,
      S_SEND_ADR = 5'h02,
      S_WAIT_IRQ = 5'h06,
      S_FLAG_CLR = 5'h07,
      S_DECIDE   = 5'h05,
      S_TX_WAIT  = 5'h04,
      S_DUMMY    = 5'h0c,
      S_RX_READ  = 5'h0d,
      S_RX_STORE = 5'h0f,
      S_STOP     = 5'h0e,
      S_FINISH   = 5'h0a,
      S_RS_SET   = 5'h0b,
      S_SL_GO    = 5'h09,
      S_SL_DUMMY = 5'h08,
      S_ACC      = 5'h18
   } state_t;

   // Device port access sequencer states.
   typedef enum logic [1:0] {
      A_IDLE   = 2'b00,
      A_STROBE = 2'b01,
      A_CAPT   = 2'b11
   } acc_state_t;

endpackage

// File: core/level_sync.sv
/*
  Two flip-flop synchroniser for one level.
  Assumes the input comes from outside the clk domain; only the second stage
  is visible to the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module level_sync
   import twb_host_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Level in and out
   input  wire logic din,
   output logic      dout
);

   typedef struct packed {
      logic meta;
      logic sync;
   } sync_t;

   sync_t s_q;
   sync_t s_d;

   // The first stage feeds only the second stage.
   always_comb
   begin
      s_d      = s_q;
      s_d.meta = din;
      s_d.sync = s_q.meta;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign dout = s_q.sync;

endmodule
`default_nettype wire

// File: core/dev_reg_access.sv
/*
  Single register access sequencer toward the bus interface.
  Assumes the interface decodes its registers on clk and returns read data
  combinationally in the cycle after the strobe; a read or write strobe
  lasts exactly one cycle so side effects happen once.
*/
`timescale 1ns/1ps
`default_nettype none
module dev_reg_access
   import twb_host_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Request from the engine
   input  wire logic       req,
   input  wire logic       req_we,
   input  wire logic [1:0] req_idx,
   input  wire logic [7:0] req_wdata,
   output logic            done,
   output logic [7:0]      rdata,
   // Device register port
   output logic            dev_sel,
   output logic            dev_we,
   output logic [1:0]      dev_idx,
   output logic [7:0]      dev_wdata,
   input  wire logic [7:0] dev_rdata
);

   typedef struct packed {
      acc_state_t st;
      logic       sel;
      logic       we;
      logic [1:0] idx;
      logic [7:0] wd;
      logic [7:0] rd;
      logic       done;
   } acc_t;

   acc_t s_q;
   acc_t s_d;

   // Strobe for one cycle, then catch read data one cycle later.
   always_comb
   begin
      s_d      = s_q;
      s_d.sel  = 1'b0;
      s_d.done = 1'b0;
      case (s_q.st)
         A_IDLE:
         begin
            if (req)
            begin
               s_d.sel = 1'b1;
               s_d.we  = req_we;
               s_d.idx = req_idx;
               s_d.wd  = req_wdata;
               s_d.st  = A_STROBE;
            end
         end
         A_STROBE:
            s_d.st = A_CAPT;
         A_CAPT:
         begin
            s_d.rd   = dev_rdata;
            s_d.done = 1'b1;
            s_d.st   = A_IDLE;
         end
         default:
            s_d.st = A_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         s_q <= '{st: A_IDLE, sel: 1'b0, we: 1'b0, idx: 2'h0, wd: RST_BYTE,
                  rd: RST_BYTE, done: 1'b0};
      else
         s_q <= s_d;
   end

   assign done      = s_q.done;
   assign rdata     = s_q.rd;
   assign dev_sel   = s_q.sel;
   assign dev_we    = s_q.we;
   assign dev_idx   = s_q.idx;
   assign dev_wdata = s_q.wd;

endmodule
`default_nettype wire

// File: core/twb_host.sv
/*
  Host controller for the two-wire bus interface: software orders master
  transfers and slave service over APB, and the engine runs them by reading
  and writing the interface's control, status and data registers.
  Assumes the interface registers sit on the same clk, and that its interrupt
  line is an asynchronous level.
*/
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Interface sets byte-done and pending flags after each byte, interrupting if enabled.
// R2 - Byte-done clears on data read in receive, data write in transmit.
// R3 - Host clears the pending flag first; polling is the alternative.
// R4 - Master transmitter checks acknowledge after each byte; missing acknowledge ends transfer.
// R5 - Every transfer ends with stop, made by clearing master select; with CTRL hold and no nack the host keeps it set on writes and zero-byte reads.
// R6 - Receiver sets acknowledge-disable before reading second-to-last byte.
// R7 - Receiver generates stop before reading the final byte.
// R8 - Repeated start: clear then set master select, then write address.
// R9 - Addressed as slave: host programs transmit select from latched direction bit.
// R10 - Any control register write clears the addressed-as-slave flag.
// R11 - Slave transfer starts on data write or dummy data read.
// R12 - Slave transmitter checks acknowledge before each further byte.
// R13 - On missing acknowledge slave switches to receive and dummy reads.
// R14 - Lost arbitration drops to slave receive, byte clock finishes.
// R15 - After the dummy byte: interrupt, arbitration flag set, master select cleared.
// R16 - Start onto busy bus is inhibited, flagged lost, without stop.
// R17 - Host checks arbitration-lost first and clears it when set.
// R18 - In wait mode the interface idles; slave wakes on start.
// R19 - Byte completion with interrupt enabled wakes processor from wait.
// R20 - In stop mode the whole interface is disabled.
// R21 - Byte-done sets at ninth clock fall, clear while byte runs.
// R22 - Pending flag set on byte, address match, lost arbitration; cleared writing 0.
// R23 - Receive mode holds clock low until data register read.
// R24 - Bus-busy sets on start, clears on stop.
// R25 - Receiver acknowledges each byte unless acknowledge-disable is set.
module twb_host
   import twb_host_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // Bus interface register port
   output logic             dev_sel,
   output logic             dev_we,
   output logic [1:0]       dev_idx,
   output logic [7:0]       dev_wdata,
   input  wire logic [7:0]  dev_rdata,
   input  wire logic        dev_irq
);

   typedef struct packed {
      state_t      st;
      state_t      ret;
      logic        acc_go;
      logic        acc_we;
      logic [1:0]  acc_idx;
      logic [7:0]  acc_wd;
      logic [7:0]  bus_status_reg;
      logic [7:0]  rem;
      logic        first;
      logic        rd;
      logic        mst;
      logic        sl_tx;
      logic        owned;
      logic        tx_full;
      logic [7:0]  tx_byte;
      logic        rx_full;
      logic [7:0]  rx_byte;
      logic        busy;
      logic        done;
      logic        nack;
      logic        arb;
      logic        go;
      logic        cfg_rd;
      logic        cfg_hold;
      logic        cfg_slave;
      logic [6:0]  cfg_addr;
      logic [7:0]  cfg_count;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } host_t;

   host_t      s_q;
   host_t      s_d;
   logic       irq_s;
   logic       acc_done;
   logic [7:0] acc_rdata;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------

   // Control value with the interface and its interrupt always enabled.
   function automatic logic [7:0] ctrl_val(input logic master_select_bit, input logic tx,
                                           input logic ack_dis);
      logic [7:0] v;
      v                 = RST_BYTE;
      v[BIT_IF_ENABLE]  = 1'b1;
      v[BIT_IRQ_ENABLE] = 1'b1;
      v[BIT_MASTER_SEL] = master_select_bit;
      v[BIT_TX_SEL]     = tx;
      v[BIT_ACK_DIS]    = ack_dis;
      return v;
   endfunction

   // Queue one device access and park in the wait state.
   function automatic host_t issue(input host_t h, input logic we,
                                   input logic [1:0] idx, input logic [7:0] wd,
                                   input state_t ret);
      host_t r;
      r         = h;
      r.acc_go  = 1'b1;
      r.acc_we  = we;
      r.acc_idx = idx;
      r.acc_wd  = wd;
      r.ret     = ret;
      r.st      = S_ACC;
      return r;
   endfunction

   // Decode of the host register offsets.
   function automatic logic mapped(input logic [7:0] a);
      return (a == OFS_CTRL) || (a == OFS_ADDR) || (a == OFS_COUNT) ||
             (a == OFS_TXDATA) || (a == OFS_RXDATA) || (a == OFS_STATUS);
   endfunction

   // ----------------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------------

   // The interrupt line is a pin; waiting on it spares status polling.
   level_sync u_irq_sync (
      .clk  (clk),
      .rst  (rst),
      .din  (dev_irq),
      .dout (irq_s)
   );

   dev_reg_access u_acc (
      .clk       (clk),
      .rst       (rst),
      .req       (s_q.acc_go),
      .req_we    (s_q.acc_we),
      .req_idx   (s_q.acc_idx),
      .req_wdata (s_q.acc_wd),
      .done      (acc_done),
      .rdata     (acc_rdata),
      .dev_sel   (dev_sel),
      .dev_we    (dev_we),
      .dev_idx   (dev_idx),
      .dev_wdata (dev_wdata),
      .dev_rdata (dev_rdata)
   );

   // ----------------------------------------------------------------------
   // Next state: APB registers first, engine after so hardware sets win
   // ----------------------------------------------------------------------
   always_comb
   begin
      logic [31:0] rv;
      rv        = RST_WORD;
      s_d       = s_q;
      s_d.acc_go  = 1'b0;
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;

      // Access phase: prepare the answer, one wait state.
      if (psel && penable && !s_q.pready)
      begin
         case (paddr)
            OFS_CTRL:   rv = {28'h0, s_q.cfg_slave, s_q.cfg_hold, s_q.cfg_rd, 1'b0};
            OFS_ADDR:   rv = {25'h0, s_q.cfg_addr};
            OFS_COUNT:  rv = {24'h0, s_q.cfg_count};
            OFS_TXDATA: rv = {24'h0, s_q.tx_byte};
            OFS_RXDATA: rv = {24'h0, s_q.rx_byte};
            OFS_STATUS: rv = {16'h0, s_q.rem, s_q.sl_tx, s_q.owned, s_q.rx_full,
                              s_q.tx_full, s_q.arb, s_q.nack, s_q.done, s_q.busy};
            default:    rv = RST_WORD;
         endcase
         s_d.pready  = 1'b1;
         s_d.pslverr = !mapped(paddr);
         s_d.prdata  = rv;
      end

      // Completing edge: writes take effect, a data read pops.
      if (psel && penable && s_q.pready)
      begin
         if (pwrite)
         begin
            case (paddr)
               OFS_CTRL:
               begin
                  s_d.cfg_rd    = pwdata[CTL_READ];
                  s_d.cfg_hold  = pwdata[CTL_HOLD];
                  s_d.cfg_slave = pwdata[CTL_SLAVE];
                  if (pwdata[CTL_GO] && !s_q.busy)
                     s_d.go = 1'b1;
               end
               OFS_ADDR:  s_d.cfg_addr  = pwdata[6:0];
               OFS_COUNT: s_d.cfg_count = pwdata[7:0];
               OFS_TXDATA:
               begin
                  // A byte written while one waits is dropped.
                  if (!s_q.tx_full)
                  begin
                     s_d.tx_byte = pwdata[7:0];
                     s_d.tx_full = 1'b1;
                  end
               end
               OFS_STATUS:
               begin
                  if (pwdata[STS_DONE])
                     s_d.done = 1'b0;
                  if (pwdata[STS_NACK])
                     s_d.nack = 1'b0;
                  if (pwdata[STS_ARB])
                     s_d.arb = 1'b0;
               end
               default: s_d.go = s_d.go;
            endcase
         end
         else if (paddr == OFS_RXDATA)
            s_d.rx_full = 1'b0;
      end

      // Transfer engine.
      case (s_q.st)
         S_INIT:
            s_d = issue(s_d, 1'b1, DEV_CTRL_IDX, ctrl_val(1'b0, 1'b0, 1'b0), S_IDLE);
         S_ACC:
         begin
            if (acc_done)
               s_d.st = s_q.ret;
         end
         S_IDLE:
         begin
            if (s_q.go)
            begin
               s_d.go    = 1'b0;
               s_d.busy  = 1'b1;
               s_d.nack  = 1'b0;
               s_d.arb   = 1'b0;
               s_d.rd    = s_q.cfg_rd;
               s_d.rem   = s_q.cfg_count;
               s_d.first = 1'b1;
               s_d.mst   = 1'b1;
               if (s_q.owned) // R8
                  s_d = issue(s_d, 1'b1, DEV_CTRL_IDX, ctrl_val(1'b0, 1'b1, 1'b0), S_RS_SET);
               else
                  s_d = issue(s_d, 1'b0, DEV_STAT_IDX, RST_BYTE, S_BUS_CHK);
            end
            else if (irq_s && s_q.cfg_slave)
            begin
               s_d.mst = 1'b0;
               s_d = issue(s_d, 1'b0, DEV_STAT_IDX, RST_BYTE, S_FLAG_CLR);
            end
         end
         S_RS_SET: // R8
            s_d = issue(s_d, 1'b1, DEV_CTRL_IDX, ctrl_val(1'b1, 1'b1, 1'b0), S_SEND_ADR);
         S_BUS_CHK:
         begin
            // Starting onto a busy bus would only be refused; wait for idle.
            if (acc_rdata[BIT_BUS_BUSY])
               s_d = issue(s_d, 1'b0, DEV_STAT_IDX, RST_BYTE, S_BUS_CHK);
            else
               s_d = issue(s_d, 1'b1, DEV_CTRL_IDX, ctrl_val(1'b1, 1'b1, 1'b0), S_SEND_ADR);
         end
         S_SEND_ADR:
         begin
            s_d.owned = 1'b1;
            s_d = issue(s_d, 1'b1, DEV_DATA_IDX, {s_q.cfg_addr, s_q.rd}, S_WAIT_IRQ); // R8
         end
         S_WAIT_IRQ:
         begin
            if (irq_s)
               s_d = issue(s_d, 1'b0, DEV_STAT_IDX, RST_BYTE, S_FLAG_CLR);
         end
         S_FLAG_CLR:
         begin
            s_d.bus_status_reg = acc_rdata;
            if (!acc_rdata[BIT_PEND_IRQ])
               s_d.st = s_q.mst ? S_WAIT_IRQ : S_IDLE;
            else // R3 R17
               s_d = issue(s_d, 1'b1, DEV_STAT_IDX,
                           acc_rdata & ~(8'h01 << BIT_PEND_IRQ) & ~(8'h01 << BIT_ARB_LOST),
                           S_DECIDE);
         end
         S_DECIDE:
         begin
            if (s_q.bus_status_reg[BIT_ARB_LOST]) // R17
            begin
               // The interface already dropped master select; no stop here.
               s_d.arb   = 1'b1;
               s_d.owned = 1'b0;
               s_d.st    = S_FINISH;
            end
            else if (!s_q.mst && s_q.bus_status_reg[BIT_ADDR_SLAVE])
            begin
               s_d.sl_tx = s_q.bus_status_reg[BIT_RW_LATCH];
               s_d = issue(s_d, 1'b1, DEV_CTRL_IDX,
                           ctrl_val(1'b0, s_q.bus_status_reg[BIT_RW_LATCH], 1'b0), S_SL_GO); // R9
            end
            else if (!s_q.mst)
            begin
               if (!s_q.sl_tx)
                  s_d.st = S_RX_READ;
               else if (s_q.bus_status_reg[BIT_RX_ACK]) // R12
               begin
                  s_d.sl_tx = 1'b0;
                  s_d = issue(s_d, 1'b1, DEV_CTRL_IDX, ctrl_val(1'b0, 1'b0, 1'b0),
                              S_SL_DUMMY); // R13
               end
               else
                  s_d.st = S_TX_WAIT;
            end
            else if (s_q.first || !s_q.rd)
            begin
               if (s_q.bus_status_reg[BIT_RX_ACK]) // R4
               begin
                  s_d.nack = 1'b1;
                  s_d.st   = S_STOP;
               end
               else if (s_q.rem == RST_BYTE)
                  s_d.st = S_STOP;
               else if (s_q.rd) // R6
                  s_d = issue(s_d, 1'b1, DEV_CTRL_IDX,
                              ctrl_val(1'b1, 1'b0, s_q.rem == 8'h01), S_DUMMY);
               else
                  s_d.st = S_TX_WAIT;
            end
            else if (s_q.rem == 8'h01)
            begin
               // Stop goes out before the last byte is read.
               s_d.owned = 1'b0;
               s_d = issue(s_d, 1'b1, DEV_CTRL_IDX, ctrl_val(1'b0, 1'b0, 1'b1),
                           S_RX_READ); // R7 R5
            end
            else if (s_q.rem == 8'h02)
               s_d = issue(s_d, 1'b1, DEV_CTRL_IDX, ctrl_val(1'b1, 1'b0, 1'b1),
                           S_RX_READ); // R6
            else
               s_d.st = S_RX_READ;
         end
         S_SL_GO:
         begin
            if (s_q.sl_tx)
               s_d.st = S_TX_WAIT;
            else
               s_d = issue(s_d, 1'b0, DEV_DATA_IDX, RST_BYTE, S_IDLE); // R11
         end
         S_SL_DUMMY:
            s_d = issue(s_d, 1'b0, DEV_DATA_IDX, RST_BYTE, S_IDLE); // R13
         S_TX_WAIT:
         begin
            // Stalls here until software supplies the next byte.
            if (s_q.tx_full)
            begin
               s_d.tx_full = 1'b0;
               s_d.first   = 1'b0;
               if (s_q.mst)
                  s_d.rem = s_q.rem - 8'h01;
               s_d = issue(s_d, 1'b1, DEV_DATA_IDX, s_q.tx_byte,
                           s_q.mst ? S_WAIT_IRQ : S_IDLE); // R11
            end
         end
         S_DUMMY:
         begin
            s_d.first = 1'b0;
            s_d = issue(s_d, 1'b0, DEV_DATA_IDX, RST_BYTE, S_WAIT_IRQ);
         end
         S_RX_READ:
         begin
            // The interface holds the clock low until this read.
            if (!s_q.rx_full)
               s_d = issue(s_d, 1'b0, DEV_DATA_IDX, RST_BYTE, S_RX_STORE);
         end
         S_RX_STORE:
         begin
            s_d.rx_byte = acc_rdata;
            s_d.rx_full = 1'b1;
            if (!s_q.mst)
               s_d.st = S_IDLE;
            else
            begin
               s_d.rem = s_q.rem - 8'h01;
               s_d.st  = (s_q.rem == 8'h01) ? S_FINISH : S_WAIT_IRQ;
            end
         end
         S_STOP:
         begin
            if (s_q.cfg_hold && !s_q.nack)
               s_d.st = S_FINISH;
            else
            begin
               s_d.owned = 1'b0;
               s_d = issue(s_d, 1'b1, DEV_CTRL_IDX, ctrl_val(1'b0, !s_q.rd, 1'b0),
                           S_FINISH); // R5
            end
         end
         S_FINISH:
         begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.st   = S_IDLE;
         end
         default:
            s_d.st = S_IDLE;
      endcase
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q     <= '0;
         s_q.st  <= S_INIT;
         s_q.ret <= S_IDLE;
      end
      else
         s_q <= s_d;
   end

   assign pready  = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign prdata  = s_q.prdata;

endmodule
`default_nettype wire

// File: tb/twb_host_checker.sv
/* Timing checker for the host's APB side and its device register port.
   Sees the top module's ports only; bound at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module twb_host_checker
   import twb_host_pkg::*;
(
   // Watched ports
   input wire logic        clk, rst, psel, penable, pready, pslverr, dev_sel, dev_we,
   input wire logic [31:0] prdata,
   input wire logic [1:0]  dev_idx,
   input wire logic [7:0]  dev_wdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Write strobes to the control and status registers of the interface.
   wire ct_wr = dev_sel && dev_we && dev_idx == DEV_CTRL_IDX;
   wire st_wr = dev_sel && dev_we && dev_idx == DEV_STAT_IDX;
   AST_PRDY_WAIT: assert property ($rose(psel && penable) |=> pready) else $error("late pready");
   AST_PRDY_ONE: assert property (pready |=> !pready) else $error("pready too long");
   AST_ERR_RDY: assert property (pslverr |-> pready) else $error("stray pslverr");
   AST_RDATA_HOLD: assert property (!pready |-> $stable(prdata)) else $error("prdata moved");
   AST_SEL_GAP: assert property (dev_sel |=> !dev_sel [*2]) else $error("strobes too close");
   AST_PEND_CLR: assert property (st_wr |-> !dev_wdata[BIT_PEND_IRQ]) else $error("pend kept");
   AST_ARB_CLR: assert property (st_wr |-> !dev_wdata[BIT_ARB_LOST]) else $error("arb kept");
   AST_ACK_RX: assert property (ct_wr && dev_wdata[BIT_ACK_DIS] |-> !dev_wdata[BIT_TX_SEL])
      else $error("ack disable in transmit");
   AST_INIT: assert property ($fell(rst) |-> ##[0:3] ct_wr && dev_wdata == 8'hc0)
      else $error("no init write");
endmodule
bind twb_host twb_host_checker chk (.*);
`default_nettype wire

// File: tb/twb_dev_model.sv
/* Behavioural model of the bus interface behind the host's device port.
   Assumes strobes on clk; one byte takes 16 clocks on the wire. */
`timescale 1ns/1ps
`default_nettype none
module twb_dev_model
   import twb_host_pkg::*;
(
   // Clock, reset and register port
   input wire logic       clk, rst, dev_sel, dev_we,
   input wire logic [1:0] dev_idx,
   input wire logic [7:0] dev_wdata,
   output logic [7:0]     dev_rdata,
   output logic           dev_irq
);
   logic [7:0] ctl, sts, dat, s;
   int cnt;
   logic nak = 0, lose = 0;
   // Unused index returns the inverted data byte.
   assign dev_rdata = dev_idx == DEV_CTRL_IDX ? ctl : dev_idx == DEV_STAT_IDX ? sts :
                      dev_idx == DEV_DATA_IDX ? dat : ~dat;
   assign dev_irq = ctl[BIT_IRQ_ENABLE] && sts[BIT_PEND_IRQ];
   // Register updates and a byte timer that runs only on a busy bus; nak and lose are bench knobs.
   always @(posedge clk)
   begin
      s = sts;
      if (cnt != 0) cnt <= cnt - 1;
      if (dev_sel && dev_we && dev_idx == DEV_CTRL_IDX)
      begin
         ctl <= dev_wdata;
         s[BIT_ADDR_SLAVE] = 1'b0;
         s[BIT_BUS_BUSY] = dev_wdata[BIT_MASTER_SEL];
      end
      if (dev_sel && dev_we && dev_idx == DEV_STAT_IDX) s = s & (dev_wdata | 8'hed);
      if (dev_sel && dev_idx == DEV_DATA_IDX)
      begin
         s[BIT_BYTE_DONE] = 1'b0;
         if (sts[BIT_BUS_BUSY]) cnt <= 16;
         if (dev_we) dat <= dev_wdata;
      end
      if (cnt == 1)
      begin
         s = s | 8'h82;
         if (!ctl[BIT_TX_SEL]) dat <= 8'ha5;
         if (lose) s[BIT_ARB_LOST] = 1'b1;
         if (lose) ctl[BIT_MASTER_SEL] <= 1'b0;
      end
      s[BIT_RX_ACK] = nak;
      sts <= rst ? 8'h81 : s;
      if (rst) ctl <= 8'h00;
      if (rst) cnt <= 0;
   end
endmodule
`default_nettype wire

// File: tb/testbench.sv
/* Self-checking bench: twb_host driven over APB, device model on its port.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
`default_nettype none
module testbench import twb_host_pkg::*;;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, e, rw[6], re[6];
   logic [7:0] paddr = 0, dev_wdata, dev_rdata, ra[6];
   logic [31:0] pwdata = 0, prdata, r, rd[6];
   logic pready, pslverr, dev_sel, dev_we, dev_irq;
   logic [1:0] dev_idx;
   int num_errors = 0, num_checks = 0;
   `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
      $display("BAD %0t value mismatch", $time); end end
   twb_host uut (.*);
   twb_dev_model mdl (.*);
   initial forever #10 clk = ~clk;
   // Verdict and end of run.
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // One APB transfer; pready and the answer are taken at the completing edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk) penable <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
      if (pready !== 1'b1) begin num_errors++; stop_test; end
   endtask
   // Clear done, start with CTRL word c, then read STATUS until done shows.
   task automatic poll(input logic [31:0] c);
      int n;
      apb(1, OFS_STATUS, 32'h2);
      apb(1, OFS_CTRL, c);
      n = 0;
      do begin apb(0, OFS_STATUS, 0); n++; end while (r[STS_DONE] !== 1'b1 && n < 200);
      if (r[STS_DONE] !== 1'b1) begin num_errors++; stop_test; end
   endtask
   initial
   begin
      ra = '{8'h14, 8'h04, 8'h04, 8'h08, 8'h08, 8'h18};
      rw = '{0, 1, 0, 1, 0, 0};
      rd = '{0, 32'h55, 32'h55, 1, 1, 0};
      re = '{0, 0, 0, 0, 0, 1};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         apb(rw[i], ra[i], rd[i]);
         `CHK(e, re[i])
         if (!rw[i] && !re[i]) `CHK(r, rd[i])
      end
      $display("register rows done");
      apb(1, OFS_TXDATA, 32'ha7);
      poll(1);
      `CHK(r[STS_NACK], 1'b0)
      `CHK(mdl.dat, 8'ha7)
      `CHK(mdl.sts[BIT_BUS_BUSY], 1'b0)
      $display("master write done");
      mdl.nak <= 1'b1;
      poll(1);
      `CHK(r[STS_NACK], 1'b1)
      `CHK(mdl.sts[BIT_BUS_BUSY], 1'b0)
      mdl.nak <= 1'b0;
      $display("nack done");
      poll(3);
      `CHK(mdl.ctl, 8'hc8)
      apb(0, OFS_RXDATA, 0);
      `CHK(r, 32'ha5)
      $display("master read done");
      mdl.lose <= 1'b1;
      poll(1);
      `CHK(r[STS_ARB], 1'b1)
      `CHK(mdl.sts[BIT_BUS_BUSY], 1'b1)
      $display("arbitration done");
      stop_test;
   end
endmodule
`default_nettype wire
